// ---- rtl/tts_sched.sv ----
// Transaction trigger scheduler with APB registers and buffer access port
`timescale 1ns/1ps
`default_nettype none
`include "tts_regs.svh"
module tts_sched #(
    parameter int unsigned TICK_CYCLES = `TTS_TICK_MS * `TTS_CLK_KHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire tts_pkg::tts_apb_req_s apb,
    output logic [$bits(tts_pkg::tts_apb_rsp_s)-1:0] apb_rsp,
    output logic [$bits(tts_pkg::tts_mem_req_s)-1:0] mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic resp_valid,
    output logic query,
    output logic irq
);
    import tts_pkg::*;

    tts_state_s st;
    tts_state_s nx;
    logic tick;
    logic upd_exp;
    logic tmo_exp;
    logic acc;
    logic commit;
    logic [4:0] ev;
    logic [4:0] clr;
    logic [31:0] full;
    logic rebase;

    // ==========================================================
    // Time base
    tts_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    tts_timer u_upd (
        .pclk(pclk),
        .presetn(presetn),
        .restart(st.upd_restart),
        .tick(tick),
        .load(st.upd_time),
        .expire(upd_exp)
    );

    tts_timer u_tmo (
        .pclk(pclk),
        .presetn(presetn),
        .restart(st.tmo_restart),
        .tick(tick),
        .load(st.tmo_time),
        .expire(tmo_exp)
    );

    assign acc = apb.psel && apb.penable;
    assign commit = acc && st.rsp.pready && !st.rsp.pslverr;
    assign full = {mem_rdata, st.sample};

    // ==========================================================
    // Next state
    always_comb begin
        nx = st;
        ev = 5'h00;
        clr = 5'h00;
        rebase = 1'b0;
        nx.query = 1'b0;
        nx.upd_restart = 1'b0;
        nx.tmo_restart = 1'b0;
        nx.mem.rd = 1'b0;
        nx.mem.wr = 1'b0;
        nx.rsp.pready = acc && !st.rsp.pready;

        // Read data captured in the first access cycle
        if (acc && !st.rsp.pready) begin
            nx.rsp.pslverr = 1'b0;
            nx.rsp.prdata = 32'h0000_0000;
            case (apb.paddr)
                `TTS_OFS_CTRL: begin
                    nx.rsp.prdata[`TTS_CTRL_EN] = st.enable;
                    nx.rsp.prdata[`TTS_CTRL_MODE +: 2] = st.mode;
                    nx.rsp.prdata[`TTS_CTRL_RTE] = st.resp_trig_en;
                end
                `TTS_OFS_UPD: nx.rsp.prdata[15:0] = st.upd_time;
                `TTS_OFS_TMO: nx.rsp.prdata = {8'h00, st.retries, st.tmo_time};
                `TTS_OFS_QTRIG: nx.rsp.prdata[10:0] = st.qtrig_addr;
                `TTS_OFS_RTRIG: nx.rsp.prdata[10:0] = st.rtrig_addr;
                `TTS_OFS_DATA: nx.rsp.prdata[10:0] = st.data_addr;
                `TTS_OFS_STATUS: nx.rsp.prdata[4:0] = st.status;
                `TTS_OFS_MASK: nx.rsp.prdata[4:0] = st.mask;
                `TTS_OFS_STATE: nx.rsp.prdata = {5'h00, st.fsm, st.retry_cnt, st.last_trig,
                    6'h00, st.have_base, st.shot_done};
                default: nx.rsp.pslverr = 1'b1;
            endcase
        end

        // Scheduler
        case (st.fsm)
            S_IDLE: begin
                if (st.enable) begin
                    case (st.mode)
                        M_CYCLIC: begin
                            if (upd_exp) begin
                                nx.fsm = S_ISSUE;
                            end
                        end
                        M_CHANGE: begin
                            if (upd_exp) begin
                                nx.mem.rd = 1'b1;
                                nx.mem.addr = st.data_addr;
                                nx.idx = 2'h0;
                                nx.after = S_SCAP;
                                nx.fsm = S_MWAIT;
                            end
                        end
                        M_SINGLE: begin
                            if (!st.shot_done) begin
                                nx.shot_done = 1'b1;
                                nx.fsm = S_ISSUE;
                            end
                        end
                        default: begin
                            nx.mem.rd = 1'b1;
                            nx.mem.addr = st.qtrig_addr;
                            nx.after = S_TCAP;
                            nx.fsm = S_MWAIT;
                        end
                    endcase
                end
            end
            S_MWAIT: nx.fsm = st.after;
            S_SCAP: begin
                if (st.idx != 2'h3) begin
                    nx.sample[{st.idx, 3'b000} +: 8] = mem_rdata;
                    nx.idx = st.idx + 2'h1;
                    nx.mem.rd = 1'b1;
                    nx.mem.addr = st.data_addr + 11'(nx.idx);
                    nx.after = S_SCAP;
                    nx.fsm = S_MWAIT;
                end else begin
                    nx.prev_sample = full;
                    nx.have_base = 1'b1;
                    nx.fsm = (st.have_base && full != st.prev_sample) ? S_ISSUE : S_IDLE;
                end
            end
            S_TCAP: begin
                nx.last_trig = mem_rdata;
                nx.have_base = 1'b1;
                nx.fsm = (st.have_base && mem_rdata != st.last_trig) ? S_ISSUE : S_IDLE;
            end
            S_ISSUE: begin
                nx.query = 1'b1;
                nx.tmo_restart = 1'b1;
                ev[`TTS_ST_QUERY] = 1'b1;
                nx.fsm = S_WAIT;
            end
            S_WAIT: begin
                if (resp_valid) begin
                    ev[`TTS_ST_RESP] = 1'b1;
                    nx.retry_cnt = 8'h00;
                    if (st.resp_trig_en) begin
                        nx.mem.rd = 1'b1;
                        nx.mem.addr = st.rtrig_addr;
                        nx.after = S_RCAP;
                        nx.fsm = S_MWAIT;
                    end else begin
                        nx.fsm = S_IDLE;
                    end
                end else if (tmo_exp && !st.query) begin
                    if (st.retry_cnt < st.retries) begin
                        nx.retry_cnt = st.retry_cnt + 8'h01;
                        ev[`TTS_ST_TMO] = 1'b1;
                        nx.fsm = S_ISSUE;
                    end else begin
                        nx.retry_cnt = 8'h00;
                        ev[`TTS_ST_DISC] = 1'b1;
                        nx.fsm = S_IDLE;
                    end
                end
            end
            S_RCAP: begin
                nx.mem.wr = 1'b1;
                nx.mem.addr = st.rtrig_addr;
                nx.mem.wdata = mem_rdata + 8'h01;
                nx.fsm = S_IDLE;
            end
            default: nx.fsm = S_IDLE;
        endcase

        // Register writes and read side effects
        if (commit && apb.pwrite) begin
            case (apb.paddr)
                `TTS_OFS_CTRL: begin
                    nx.enable = apb.pwdata[`TTS_CTRL_EN];
                    nx.mode = tts_mode_e'(apb.pwdata[`TTS_CTRL_MODE +: 2]);
                    nx.resp_trig_en = apb.pwdata[`TTS_CTRL_RTE];
                    if (nx.mode != st.mode) begin
                        rebase = 1'b1;
                    end
                    if (nx.enable && !st.enable) begin
                        nx.shot_done = 1'b0;
                        rebase = 1'b1;
                        nx.upd_restart = 1'b1;
                    end
                end
                `TTS_OFS_UPD: begin
                    nx.upd_time = apb.pwdata[15:0];
                    nx.upd_restart = 1'b1;
                end
                `TTS_OFS_TMO: begin
                    nx.tmo_time = apb.pwdata[15:0];
                    nx.retries = apb.pwdata[`TTS_TMO_RETRY +: 8];
                end
                `TTS_OFS_QTRIG: begin
                    if (tts_qaddr_ok(apb.pwdata[10:0]) && apb.pwdata[31:11] == 21'h000000) begin
                        nx.qtrig_addr = apb.pwdata[10:0];
                        rebase = 1'b1;
                    end else begin
                        ev[`TTS_ST_CFG] = 1'b1;
                    end
                end
                `TTS_OFS_RTRIG: begin
                    if (tts_raddr_ok(apb.pwdata[10:0]) && apb.pwdata[31:11] == 21'h000000) begin
                        nx.rtrig_addr = apb.pwdata[10:0];
                    end else begin
                        ev[`TTS_ST_CFG] = 1'b1;
                    end
                end
                `TTS_OFS_DATA: begin
                    nx.data_addr = apb.pwdata[10:0];
                    rebase = 1'b1;
                end
                `TTS_OFS_MASK: nx.mask = apb.pwdata[4:0];
                default: nx.mask = st.mask;
            endcase
        end
        // Drop a sample read begun under the old setting
        if (rebase) begin
            nx.have_base = 1'b0;
            if ((nx.fsm == S_MWAIT && nx.after != S_RCAP) || nx.fsm == S_SCAP
                || nx.fsm == S_TCAP) begin
                nx.fsm = S_IDLE;
            end
        end
        if (commit && !apb.pwrite && apb.paddr == `TTS_OFS_STATUS) begin
            clr = st.rsp.prdata[4:0];
        end
        nx.status = (st.status & ~clr) | ev;
        nx.irq = |(nx.status & nx.mask);
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.upd_time <= `TTS_UPD_RST;
            st.tmo_time <= `TTS_TMO_RST;
            st.retries <= `TTS_RETRY_RST;
            st.qtrig_addr <= `TTS_QTRIG_RST;
            st.rtrig_addr <= `TTS_RTRIG_RST;
            st.data_addr <= `TTS_DATA_RST;
        end else begin
            st <= nx;
        end
    end

    assign apb_rsp = st.rsp;
    assign mem_req = st.mem;
    assign query = st.query;
    assign irq = st.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_issue;
        st.fsm == S_ISSUE ##1 query && st.fsm == S_WAIT;
    endsequence

    sequence s_resp_read;
        st.mem.rd && st.mem.addr == st.rtrig_addr ##1 st.fsm == S_RCAP;
    endsequence

    cyclic_issue_a: assert property (
        st.fsm == S_IDLE && st.enable && st.mode == M_CYCLIC && upd_exp |=> s_issue)
        else $error("cyclic interval passed without a query");
    change_issue_a: assert property (
        st.fsm == S_SCAP && st.idx == 2'h3 && st.have_base && full != st.prev_sample
        |=> s_issue)
        else $error("changed data area did not raise a query");
    nochange_quiet_a: assert property (
        st.fsm == S_SCAP && st.idx == 2'h3 && full == st.prev_sample |=> st.fsm == S_IDLE)
        else $error("unchanged data area raised a query");
    single_once_a: assert property (
        st.fsm == S_IDLE && st.mode == M_SINGLE && st.shot_done |=> st.fsm != S_ISSUE)
        else $error("single shot query issued twice");
    trig_issue_a: assert property (
        st.fsm == S_TCAP && st.have_base && mem_rdata != st.last_trig |=> s_issue)
        else $error("trigger byte change did not raise a query");
    resp_incr_a: assert property (
        st.fsm == S_WAIT && resp_valid && st.resp_trig_en |=> s_resp_read
        ##1 st.mem.wr && st.mem.wdata == 8'($past(mem_rdata) + 8'h01))
        else $error("response trigger byte not incremented");
    resp_untouched_a: assert property (
        st.fsm == S_WAIT && resp_valid && !st.resp_trig_en |=> !st.mem.wr [*3])
        else $error("response trigger byte written while disabled");
    raddr_range_a: assert property (tts_raddr_ok(st.rtrig_addr))
        else $error("response trigger address out of range");
    qaddr_range_a: assert property (tts_qaddr_ok(st.qtrig_addr))
        else $error("query trigger address out of range");
    retry_issue_a: assert property (
        st.fsm == S_WAIT && !resp_valid && tmo_exp && !query && st.retry_cnt < st.retries
        |=> st.retry_cnt == $past(st.retry_cnt) + 8'h01 ##0 s_issue)
        else $error("timeout did not resend the query");
    retry_stop_a: assert property (
        st.fsm == S_WAIT && !resp_valid && tmo_exp && !query && st.retry_cnt >= st.retries
        |=> st.fsm == S_IDLE && st.status[`TTS_ST_DISC])
        else $error("retry limit not honoured");
    trig_wrap_a: assert property (
        st.fsm == S_RCAP && mem_rdata == 8'hff |=> st.mem.wr && st.mem.wdata == 8'h00)
        else $error("trigger byte did not wrap");
    rebase_drop_a: assert property (
        rebase |=> !st.have_base && st.fsm != S_SCAP && st.fsm != S_TCAP
        && !(st.fsm == S_MWAIT && st.after != S_RCAP))
        else $error("sample read survived a setting change");
    query_pulse_a: assert property (query |=> !query)
        else $error("query pulse longer than one cycle");
    pready_pulse_a: assert property (st.rsp.pready |=> !st.rsp.pready)
        else $error("ready pulse longer than one cycle");
    stat_clear_a: assert property (
        commit && !apb.pwrite && apb.paddr == `TTS_OFS_STATUS && ev == 5'h00
        |=> (st.status & $past(st.rsp.prdata[4:0])) == 5'h00)
        else $error("status read did not clear its bits");
    qcfg_refuse_a: assert property (
        commit && apb.pwrite && apb.paddr == `TTS_OFS_QTRIG && !tts_qaddr_ok(apb.pwdata[10:0])
        |=> st.status[`TTS_ST_CFG] && st.qtrig_addr == $past(st.qtrig_addr))
        else $error("query trigger address not refused");
    rcfg_refuse_a: assert property (
        commit && apb.pwrite && apb.paddr == `TTS_OFS_RTRIG && !tts_raddr_ok(apb.pwdata[10:0])
        |=> st.status[`TTS_ST_CFG] && st.rtrig_addr == $past(st.rtrig_addr))
        else $error("response trigger address not refused");
endmodule
`default_nettype wire

// ---- rtl/tts_regs.svh ----
// Register map, field positions, reset values and timing counts of the trigger scheduler
`ifndef TTS_REGS_SVH
`define TTS_REGS_SVH

// ==========================================================
// Register offsets
`define TTS_OFS_CTRL 8'h00
`define TTS_OFS_UPD 8'h04
`define TTS_OFS_TMO 8'h08
`define TTS_OFS_QTRIG 8'h0c
`define TTS_OFS_RTRIG 8'h10
`define TTS_OFS_DATA 8'h14
`define TTS_OFS_STATUS 8'h18
`define TTS_OFS_MASK 8'h1c
`define TTS_OFS_STATE 8'h20

// ==========================================================
// Field positions
`define TTS_CTRL_EN 0
`define TTS_CTRL_MODE 1
`define TTS_CTRL_RTE 3
`define TTS_TMO_RETRY 16
`define TTS_ST_QUERY 0
`define TTS_ST_RESP 1
`define TTS_ST_TMO 2
`define TTS_ST_DISC 3
`define TTS_ST_CFG 4

// ==========================================================
// Reset values and address ranges
`define TTS_UPD_RST 16'h0001
`define TTS_TMO_RST 16'h000a
`define TTS_RETRY_RST 8'h03
`define TTS_QTRIG_RST 11'h200
`define TTS_RTRIG_RST 11'h000
`define TTS_DATA_RST 11'h400
`define TTS_RLO_MAX 11'h1ff
`define TTS_QLO_MIN 11'h200
`define TTS_QLO_MAX 11'h3ff
`define TTS_SHARED_MIN 11'h400
`define TTS_BUF_TOP 11'h7ff

// ==========================================================
// Timing
`define TTS_TICK_MS 10
`define TTS_CLK_KHZ 250000

`endif

// ---- rtl/tts_pkg.sv ----
// Types and helper functions of the trigger scheduler
package tts_pkg;
    `include "tts_regs.svh"

    typedef enum logic [1:0] {M_CYCLIC, M_CHANGE, M_SINGLE, M_TRIGGER} tts_mode_e;
    typedef enum logic [2:0] {S_IDLE, S_MWAIT, S_SCAP, S_TCAP, S_ISSUE, S_WAIT, S_RCAP} tts_fsm_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tts_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tts_apb_rsp_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [10:0] addr;
        logic [7:0] wdata;
    } tts_mem_req_s;

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } tts_tick_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic expire;
    } tts_timer_s;

    typedef struct packed {
        tts_fsm_e fsm;
        tts_fsm_e after;
        logic enable;
        tts_mode_e mode;
        logic resp_trig_en;
        logic [15:0] upd_time;
        logic [15:0] tmo_time;
        logic [7:0] retries;
        logic [7:0] retry_cnt;
        logic [10:0] qtrig_addr;
        logic [10:0] rtrig_addr;
        logic [10:0] data_addr;
        logic [4:0] status;
        logic [4:0] mask;
        logic shot_done;
        logic have_base;
        logic [7:0] last_trig;
        logic [1:0] idx;
        logic [23:0] sample;
        logic [31:0] prev_sample;
        logic upd_restart;
        logic tmo_restart;
        logic query;
        logic irq;
        tts_mem_req_s mem;
        tts_apb_rsp_s rsp;
    } tts_state_s;

    function automatic logic tts_qaddr_ok(input logic [10:0] a);
        return (a >= `TTS_QLO_MIN && a <= `TTS_QLO_MAX) || (a >= `TTS_SHARED_MIN);
    endfunction

    function automatic logic tts_raddr_ok(input logic [10:0] a);
        return (a <= `TTS_RLO_MAX) || (a >= `TTS_SHARED_MIN);
    endfunction

    function automatic logic [15:0] tts_min1(input logic [15:0] v);
        return (v == 16'h0000) ? 16'h0001 : v;
    endfunction
endpackage

// ---- rtl/tts_tick.sv ----
// Divider giving a one-cycle pulse every 10 ms
`timescale 1ns/1ps
`default_nettype none
module tts_tick #(
    parameter int unsigned CYCLES = 2500000
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    import tts_pkg::*;

    tts_tick_s st;
    tts_tick_s nx;

    always_comb begin
        nx = st;
        nx.tick = 1'b0;
        if (st.cnt >= 32'(CYCLES - 1)) begin
            nx.cnt = 32'h0000_0000;
            nx.tick = 1'b1;
        end else begin
            nx.cnt = st.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign tick = st.tick;
endmodule
`default_nettype wire

// ---- rtl/tts_timer.sv ----
// Interval timer counting 10 ms ticks down from a loaded value
`timescale 1ns/1ps
`default_nettype none
module tts_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic tick,
    input wire logic [15:0] load,
    output logic expire
);
    import tts_pkg::*;

    tts_timer_s st;
    tts_timer_s nx;

    always_comb begin
        nx = st;
        nx.expire = 1'b0;
        if (restart) begin
            nx.cnt = tts_min1(load);
        end else if (tick) begin
            if (st.cnt <= 16'h0001) begin
                nx.expire = 1'b1;
                nx.cnt = tts_min1(load);
            end else begin
                nx.cnt = st.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.cnt <= 16'h0001;
        end else begin
            st <= nx;
        end
    end

    assign expire = st.expire;

    // ==========================================================
    // Checks
    tick_expire_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && !restart && st.cnt <= 16'h0001 |=> expire && st.cnt == tts_min1($past(load)))
        else $error("timer did not expire on its last tick");
    expire_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        expire |-> $past(tick) && !$past(restart) && $past(st.cnt) <= 16'h0001)
        else $error("timer expired without a final tick");
endmodule
`default_nettype wire

// ---- test/tts_mem_model.sv ----
// Behavioural model of the shared buffer memory beside the scheduler
`timescale 1ns/1ps
`default_nettype none
module tts_mem_model (
    input wire logic pclk,
    input wire tts_pkg::tts_mem_req_s req,
    output logic [7:0] rdata
);
    import tts_pkg::*;
    logic [7:0] mem [0:2047];
    initial begin
        rdata = 8'h00;
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 8'h00;
        end
    end
    // ==========================================================
    // Read one cycle after the strobe, else a changing pattern
    always @(posedge pclk) begin
        if (req.rd) begin
            rdata <= mem[req.addr];
        end else begin
            rdata <= ~rdata;
        end
        if (req.wr) begin
            mem[req.addr] <= req.wdata;
        end
    end
endmodule
`default_nettype wire

// ---- test/tts_sched_test.sv ----
// Self-checking testbench of the trigger scheduler
`timescale 1ns/1ps
`default_nettype none
`include "tts_regs.svh"
module tts_sched_test;
    import tts_pkg::*;
    localparam int TICK = 20;
    logic pclk, presetn, query, irq, auto_resp, err;
    logic resp_valid = 1'b0;
    tts_apb_req_s apb;
    logic [33:0] apb_rsp;
    logic [20:0] mem_req;
    logic [7:0] mem_rdata;
    tts_apb_rsp_s rsp;
    tts_mem_req_s mreq;
    int fail_count = 0, num_checks = 0, qcnt = 0, qgap = 0, qlast = 0, cyc = 0, q0;
    logic [31:0] rd;
    logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    logic [31:0] rst [8] = '{0, 1, 32'h0003000a, 32'h200, 0, 32'h400, 0, 0};
    assign rsp = apb_rsp;
    assign mreq = mem_req;
    tts_sched #(.TICK_CYCLES(TICK)) dut (.pclk(pclk), .presetn(presetn), .apb(apb),
        .apb_rsp(apb_rsp), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .resp_valid(resp_valid), .query(query), .irq(irq));
    tts_mem_model mdl (.pclk(pclk), .req(mreq), .rdata(mem_rdata));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ==========================================================
    // Query monitor and slave responder
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        resp_valid <= auto_resp && query;
        if (query) begin
            qcnt <= qcnt + 1;
            qgap <= cyc - qlast;
            qlast <= cyc;
        end
    end
    // ==========================================================
    // Tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        apb <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        apb.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        apb <= '0;
        if (rsp.pready !== 1'b1) begin
            check(32'h0, 32'h1);
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic wait_query();
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (query !== 1'b1 && n < 500);
        if (query !== 1'b1) begin
            check(32'h0, 32'h1);
            finish_test();
        end
    endtask
    // ==========================================================
    // Scenarios
    initial begin
        apb = '0;
        presetn = 1'b0;
        auto_resp = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ofs[i]) rdc(ofs[i], rst[i]);
        rdc(`TTS_OFS_STATE, 32'h0);
        rdc(8'h24, 32'h0);
        check(32'(err), 32'h1);
        wr(`TTS_OFS_QTRIG, 32'h1ff);
        rdc(`TTS_OFS_QTRIG, 32'h200);
        wr(`TTS_OFS_QTRIG, 32'h400);
        rdc(`TTS_OFS_QTRIG, 32'h400);
        wr(`TTS_OFS_RTRIG, 32'h200);
        rdc(`TTS_OFS_RTRIG, 32'h0);
        wr(`TTS_OFS_RTRIG, 32'h1ff);
        rdc(`TTS_OFS_RTRIG, 32'h1ff);
        wr(`TTS_OFS_MASK, 32'h10);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h1);
        rdc(`TTS_OFS_STATUS, 32'h10);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        mdl.mem[11'h1ff] = 8'hff;
        q0 = qcnt;
        wr(`TTS_OFS_UPD, 32'h2);
        wr(`TTS_OFS_CTRL, 32'h9);
        wait_query();
        wait_query();
        wait_query();
        @(posedge pclk);
        check(32'(qgap), 32'(2 * TICK));
        repeat (10) @(posedge pclk);
        check(32'(qcnt - q0), 32'h3);
        check(32'(mdl.mem[11'h1ff]), 32'h02);
        wr(`TTS_OFS_CTRL, 32'h0);
        q0 = qcnt;
        wr(`TTS_OFS_CTRL, 32'h5);
        repeat (300) @(posedge pclk);
        check(32'(qcnt - q0), 32'h1);
        check(32'(mdl.mem[11'h1ff]), 32'h02);
        wr(`TTS_OFS_CTRL, 32'h0);
        wr(`TTS_OFS_QTRIG, 32'h200);
        mdl.mem[11'h200] = 8'hff;
        wr(`TTS_OFS_CTRL, 32'h7);
        repeat (50) @(posedge pclk);
        q0 = qcnt;
        repeat (50) @(posedge pclk);
        check(32'(qcnt - q0), 32'h0);
        mdl.mem[11'h401] = 8'h5a;
        mdl.mem[11'h200] = 8'h00;
        wait_query();
        repeat (50) @(posedge pclk);
        check(32'(qcnt - q0), 32'h1);
        wr(`TTS_OFS_UPD, 32'h1);
        wr(`TTS_OFS_CTRL, 32'h3);
        repeat (100) @(posedge pclk);
        q0 = qcnt;
        repeat (100) @(posedge pclk);
        check(32'(qcnt - q0), 32'h0);
        mdl.mem[11'h402] = 8'h77;
        repeat (60) @(posedge pclk);
        check(32'(qcnt - q0), 32'h1);
        wr(`TTS_OFS_CTRL, 32'h0);
        auto_resp <= 1'b0;
        wr(`TTS_OFS_TMO, 32'h00020001);
        apb_xfer(1'b0, `TTS_OFS_STATUS, 32'h0);
        q0 = qcnt;
        wr(`TTS_OFS_CTRL, 32'h5);
        repeat (200) @(posedge pclk);
        check(32'(qcnt - q0), 32'h3);
        rdc(`TTS_OFS_STATUS, 32'h0d);
        finish_test();
    end
endmodule
`default_nettype wire
